// File: accel_fifo_pkg.sv
// Purpose: Shared constants and types for the acceleration sample buffer
// Assumes: Byte-wide register port with six address bits
// Notes: Data bytes sit at consecutive addresses, low byte first per axis
package accel_fifo_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [5:0] ADDR_X_LOW = 6'h32;
  localparam logic [5:0] ADDR_Z_HIGH = 6'h37;
  localparam logic [5:0] ADDR_BUFFER_CONTROL = 6'h38;
  localparam logic [5:0] ADDR_BUFFER_STATUS = 6'h39;

  // ----------------------------------------------------------------------
  // Field layout of buffer_control
  // ----------------------------------------------------------------------
  localparam int MODE_MSB = 7;
  localparam int MODE_LSB = 6;
  localparam int TRIG_SEL_BIT = 5;
  localparam int COUNT_MSB = 4;
  localparam int COUNT_LSB = 0;
  localparam logic [7:0] BUFFER_CONTROL_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // Field layout of buffer_status and interrupt sources
  // ----------------------------------------------------------------------
  localparam int STATUS_TRIG_BIT = 7;
  localparam int SRC_DATA_READY = 7;
  localparam int SRC_ACTIVITY = 4;
  localparam int SRC_INACTIVITY = 3;
  localparam int SRC_WATERMARK = 1;
  localparam int SRC_OVERRUN = 0;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int BUFFER_DEPTH = 32;
  localparam int AXIS_WIDTH = 16;
  localparam int SAMPLE_WIDTH = 3 * AXIS_WIDTH;

  typedef enum logic [1:0] {
    MODE_BYPASS,
    MODE_FILL,
    MODE_STREAM,
    MODE_TRIGGER
  } buffer_mode_type;

endpackage

// File: sample_handoff.sv
// Purpose: Carries one sample word from the sample clock to the system clock
// Assumes: Words arrive far slower than the round trip of the handshake
// Notes: A word offered while a handoff is in flight is dropped
`timescale 1ns/1ps
module sample_handoff
#(
  parameter int WIDTH = 48
)
(
  input wire logic sample_clk,
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_pulse,
  output logic [WIDTH-1:0] out_data
);

  logic req_q;
  logic ack_s1_q;
  logic ack_s2_q;
  logic [WIDTH-1:0] hold_q;
  logic req_s1_q;
  logic req_s2_q;
  logic req_s3_q;
  logic ack_q;

  // ----------------------------------------------------------------------
  // Sample clock side
  // ----------------------------------------------------------------------
  always_ff @(posedge sample_clk or posedge rst)
  begin
    if (rst)
    begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end
    else
    begin
      ack_s1_q <= ack_q;
      ack_s2_q <= ack_s1_q;
    end
  end

  always_ff @(posedge sample_clk or posedge rst)
  begin
    if (rst)
    begin
      req_q <= 1'b0;
      hold_q <= '0;
    end
    else if (in_valid && (req_q == ack_s2_q))
    begin
      hold_q <= in_data;
      req_q <= ~req_q;
    end
  end

  // ----------------------------------------------------------------------
  // System clock side
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
      ack_q <= 1'b0;
    end
    else
    begin
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      ack_q <= req_s2_q;
    end
  end

  // Hold word is stable while the request toggle is unacknowledged
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      out_pulse <= 1'b0;
      out_data <= '0;
    end
    else
    begin
      out_pulse <= req_s2_q ^ req_s3_q;
      if (req_s2_q ^ req_s3_q)
      begin
        out_data <= hold_q;
      end
    end
  end

endmodule

// File: accel_sample_fifo_control.sv
// Purpose: Sample buffer with bypass, fill, stream and triggered capture
// Assumes: Host register accesses are framed by reg_cs on the system clock
// Notes: Axis data pops one level when a transaction that read it ends
//
// Operation
// - Mode 00 bypasses the buffer; sample count acts only by setting watermark at 0.
// - Mode 01 stores up to 32 samples, then stops until not full.
// - Mode 10 keeps newest 32 samples, dropping the oldest when full.
// - Mode 11 keeps pre-trigger samples, then collects until full.
// - Trigger select 0 picks first interrupt pin, 1 picks second.
// - A sample count of 0 sets the watermark flag in any mode.
// - Fill and stream raise watermark when stored entries reach count.
// - Triggered mode keeps sample-count samples (32 when count is 0) in the buffer, plus one in the output stage, from before the trigger.
// - Status bit 7 reads 1 after a trigger, else 0.
// - Status entry field reports samples available to read.
// - A transaction with one or more axis data reads pops one buffer level when it ends.
// - Buffer holds 32; available count reaches 33 via output stage.
// - Ready, watermark, overrun flags set on events, cleared by data read.
// - Sleep stops buffer writes and suppresses sample-ready.
// - Sources with map bit 0 go to first pin, 1 to second, ORed.
`timescale 1ns/1ps
module accel_sample_fifo_control
#(
  parameter int DEPTH = accel_fifo_pkg::BUFFER_DEPTH
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sample_clk,
  input wire logic sample_valid,
  input wire logic [accel_fifo_pkg::AXIS_WIDTH-1:0] sample_x,
  input wire logic [accel_fifo_pkg::AXIS_WIDTH-1:0] sample_y,
  input wire logic [accel_fifo_pkg::AXIS_WIDTH-1:0] sample_z,
  input wire logic reg_cs,
  input wire logic [5:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic sleep_mode,
  input wire logic [7:0] int_enable,
  input wire logic [7:0] int_map,
  input wire logic activity_event,
  input wire logic inactivity_event,
  output logic first_interrupt_pin,
  output logic second_interrupt_pin,
  output logic [7:0] int_source_flags
);

  import accel_fifo_pkg::*;

  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;

  if (DEPTH != (1 << PW) || DEPTH < 2 || DEPTH > 32)
  begin
    $error("DEPTH must be a power of two from 2 to 32");
  end

  function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
    ptr_next = p + PW'(1);
  endfunction

  function automatic logic is_data_addr(input logic [5:0] a);
    is_data_addr = (a >= ADDR_X_LOW) && (a <= ADDR_Z_HIGH);
  endfunction

  // ----------------------------------------------------------------------
  // Sample crossing
  // ----------------------------------------------------------------------
  logic new_sample;
  logic [SAMPLE_WIDTH-1:0] new_word;

  sample_handoff #(.WIDTH(SAMPLE_WIDTH)) u_sample_handoff
  (
    .sample_clk(sample_clk),
    .clk(clk),
    .rst(rst),
    .in_valid(sample_valid),
    .in_data({sample_z, sample_y, sample_x}),
    .out_pulse(new_sample),
    .out_data(new_word)
  );

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [7:0] control_q;
  logic [SAMPLE_WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] rd_ptr_q;
  logic [PW-1:0] wr_ptr_q;
  logic [CW-1:0] count_q;
  logic [SAMPLE_WIDTH-1:0] out_q;
  logic out_valid_q, triggered_q, data_read_seen_q, cs_prev_q;
  logic trig_prev_q, data_ready_q, watermark_q, overrun_q;

  buffer_mode_type mode;
  logic [COUNT_MSB-COUNT_LSB:0] samples;
  logic trig_sel, pop, fifo_empty, refill, take, to_out, accept;
  logic need_drop, to_fifo, drop, overrun_evt, trig_level, trig_evt, ctrl_write;
  logic [CW-1:0] count_eff;
  logic [CW-1:0] samples_ext;
  logic [7:0] sources;

  assign mode = buffer_mode_type'(control_q[MODE_MSB:MODE_LSB]);
  assign samples = control_q[COUNT_MSB:COUNT_LSB];
  assign trig_sel = control_q[TRIG_SEL_BIT];
  assign samples_ext = CW'(samples);
  assign ctrl_write = reg_wr && (reg_addr == ADDR_BUFFER_CONTROL);

  // ----------------------------------------------------------------------
  // Transfer decisions
  // ----------------------------------------------------------------------
  always_comb
  begin
    pop = cs_prev_q && !reg_cs && data_read_seen_q;
    fifo_empty = (count_q == '0);
    refill = pop && !fifo_empty && (mode != MODE_BYPASS);
    count_eff = refill ? count_q - CW'(1) : count_q;
    take = new_sample && !sleep_mode && (mode != MODE_BYPASS);
    to_out = take && fifo_empty && (!out_valid_q || pop);
    accept = 1'b1;
    need_drop = 1'b0;
    unique case (mode)
      MODE_BYPASS:
        accept = 1'b0;
      MODE_FILL:
        accept = count_eff < CW'(DEPTH);
      MODE_STREAM:
        need_drop = count_eff >= CW'(DEPTH);
      MODE_TRIGGER:
      begin
        if (triggered_q)
          accept = count_eff < CW'(DEPTH);
        else
        begin
          need_drop = (samples_ext != '0) && (count_eff >= samples_ext);
          need_drop = need_drop || (count_eff >= CW'(DEPTH));
        end
      end
    endcase
    to_fifo = take && !to_out && accept;
    drop = to_fifo && need_drop && !refill;
    overrun_evt = take && !to_out && (!accept || (need_drop && mode == MODE_STREAM));
    trig_level = trig_sel ? second_interrupt_pin : first_interrupt_pin;
    trig_evt = (mode == MODE_TRIGGER) && !triggered_q && trig_level && !trig_prev_q;
  end

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      control_q <= BUFFER_CONTROL_RESET;
    else if (ctrl_write)
      control_q <= reg_wdata;
  end

  // ----------------------------------------------------------------------
  // Host transaction tracking
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cs_prev_q <= 1'b0;
      data_read_seen_q <= 1'b0;
    end
    else
    begin
      cs_prev_q <= reg_cs;
      if (!reg_cs)
        data_read_seen_q <= 1'b0;
      else if (reg_rd && is_data_addr(reg_addr))
        data_read_seen_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Buffer storage
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (to_fifo)
    begin
      mem_q[wr_ptr_q] <= new_word;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_ptr_q <= '0;
      wr_ptr_q <= '0;
      count_q <= '0;
    end
    else if (mode == MODE_BYPASS)
    begin
      rd_ptr_q <= '0;
      wr_ptr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (refill || drop)
        rd_ptr_q <= ptr_next(rd_ptr_q);
      if (to_fifo)
        wr_ptr_q <= ptr_next(wr_ptr_q);
      count_q <= count_q + CW'(to_fifo) - CW'(refill) - CW'(drop);
    end
  end

  // ----------------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      out_q <= '0;
      out_valid_q <= 1'b0;
    end
    else if (mode == MODE_BYPASS)
    begin
      if (new_sample && !sleep_mode)
      begin
        out_q <= new_word;
        out_valid_q <= 1'b1;
      end
      else if (pop)
      begin
        out_valid_q <= 1'b0;
      end
    end
    else if (refill)
    begin
      out_q <= mem_q[rd_ptr_q];
      out_valid_q <= 1'b1;
    end
    else if (to_out)
    begin
      out_q <= new_word;
      out_valid_q <= 1'b1;
    end
    else if (pop)
    begin
      out_valid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Trigger capture
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      trig_prev_q <= 1'b0;
      triggered_q <= 1'b0;
    end
    else
    begin
      trig_prev_q <= trig_level;
      if (trig_evt)
        triggered_q <= 1'b1;
      else if (ctrl_write)
        triggered_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Event flags, set wins over clear
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      data_ready_q <= 1'b0;
      watermark_q <= 1'b0;
      overrun_q <= 1'b0;
    end
    else
    begin
      if ((take && (to_out || to_fifo)) ||
          (mode == MODE_BYPASS && new_sample && !sleep_mode))
        data_ready_q <= 1'b1;
      else if (pop)
        data_ready_q <= 1'b0;
      if (samples == '0)
        watermark_q <= 1'b1;
      else if ((mode == MODE_FILL || mode == MODE_STREAM) && count_q >= samples_ext)
        watermark_q <= 1'b1;
      else if (pop)
        watermark_q <= 1'b0;
      if (overrun_evt)
        overrun_q <= 1'b1;
      else if (pop)
        overrun_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt pins
  // ----------------------------------------------------------------------
  always_comb
  begin
    sources = '0;
    sources[SRC_DATA_READY] = data_ready_q;
    sources[SRC_ACTIVITY] = activity_event;
    sources[SRC_INACTIVITY] = inactivity_event;
    sources[SRC_WATERMARK] = watermark_q;
    sources[SRC_OVERRUN] = overrun_q;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      first_interrupt_pin <= 1'b0;
      second_interrupt_pin <= 1'b0;
      int_source_flags <= '0;
    end
    else
    begin
      first_interrupt_pin <= |(sources & int_enable & ~int_map);
      second_interrupt_pin <= |(sources & int_enable & int_map);
      int_source_flags <= sources;
    end
  end

  // ----------------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata <= '0;
    end
    else if (reg_rd)
    begin
      if (is_data_addr(reg_addr))
        reg_rdata <= out_q[8*(reg_addr - ADDR_X_LOW) +: 8];
      else if (reg_addr == ADDR_BUFFER_CONTROL)
        reg_rdata <= control_q;
      else if (reg_addr == ADDR_BUFFER_STATUS)
      begin
        reg_rdata <= '0;
        reg_rdata[STATUS_TRIG_BIT] <= triggered_q;
        reg_rdata[5:0] <= 6'(count_q) + 6'(out_valid_q);
      end
      else
        reg_rdata <= '0;
    end
  end

endmodule

// File: fifo_checker_assertions.sv
// Purpose: Port checker for the acceleration sample buffer
// Assumes: All watched signals belong to the clk domain
// Notes: Bound onto accel_sample_fifo_control
`timescale 1ns/1ps
module fifo_checker
  import accel_fifo_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_cs,
  input wire logic [5:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic sleep_mode,
  input wire logic [7:0] int_enable,
  input wire logic [7:0] int_map,
  input wire logic first_interrupt_pin,
  input wire logic second_interrupt_pin,
  input wire logic [7:0] int_source_flags
);
  // --------------------------------------------------------------------
  // Helpers and properties
  // --------------------------------------------------------------------
  logic [7:0] ctl_q;
  logic [4:0] slp_q;
  logic ctl_wr;
  assign ctl_wr = reg_cs && reg_wr && reg_addr == ADDR_BUFFER_CONTROL;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ctl_q <= BUFFER_CONTROL_RESET;
    else if (ctl_wr)
      ctl_q <= reg_wdata;
  end
  // Cycles spent asleep, saturating
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      slp_q <= 5'h00;
    else if (!sleep_mode)
      slp_q <= 5'h00;
    else if (slp_q != 5'h1f)
      slp_q <= slp_q + 5'h01;
  end
  AST_PIN_FIRST: assert property ($stable(int_enable) && $stable(int_map) |->
    first_interrupt_pin == |(int_source_flags & int_enable & ~int_map))
    else $error("first pin differs from routed sources");
  AST_PIN_SECOND: assert property ($stable(int_enable) && $stable(int_map) |->
    second_interrupt_pin == |(int_source_flags & int_enable & int_map))
    else $error("second pin differs from routed sources");
  AST_WM_ZERO: assert property (ctl_wr && reg_wdata[COUNT_MSB:COUNT_LSB] == 5'h00
    |-> ##[1:3] int_source_flags[SRC_WATERMARK]) else $error("count zero left watermark low");
  AST_STATUS_FMT: assert property (reg_cs && reg_rd && reg_addr == ADDR_BUFFER_STATUS
    |=> reg_rdata[6] == 1'b0 && reg_rdata[5:0] <= 6'h21) else $error("status field out of range");
  AST_UNMAPPED: assert property (reg_rd && (reg_addr < 6'h30 || reg_addr > ADDR_BUFFER_STATUS)
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  AST_RDATA_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  AST_SLEEP: assert property (slp_q == 5'h1f |-> !$rose(int_source_flags[SRC_DATA_READY]))
    else $error("data ready rose in sleep");
  AST_CTL_READBACK: assert property (reg_cs && reg_rd && reg_addr == ADDR_BUFFER_CONTROL
    |=> reg_rdata == ctl_q) else $error("control readback mismatch");
endmodule

bind accel_sample_fifo_control fifo_checker u_fifo_checker (.clk(clk), .rst(rst),
  .reg_cs(reg_cs), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sleep_mode(sleep_mode),
  .int_enable(int_enable), .int_map(int_map), .first_interrupt_pin(first_interrupt_pin),
  .second_interrupt_pin(second_interrupt_pin), .int_source_flags(int_source_flags));

// File: host_model.sv
// Purpose: Host side of the register port
// Assumes: One strobe per two clk cycles inside a reg_cs window
// Notes: Address and data are inverted on release
`timescale 1ns/1ps
module host_model
  import accel_fifo_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  output logic reg_cs,
  output logic [5:0] reg_addr,
  output logic reg_rd,
  output logic reg_wr,
  output logic [7:0] reg_wdata
);
  // --------------------------------------------------------------------
  // Register cycles
  // --------------------------------------------------------------------
  initial
  begin
    reg_cs = 0;
    reg_addr = 6'h00;
    reg_rd = 0;
    reg_wr = 0;
    reg_wdata = 8'h00;
  end
  task automatic go(input logic [5:0] a, input logic w, input logic [7:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = w;
    reg_rd = !w;
    @(posedge clk);
    #1;
    reg_wr = 0;
    reg_rd = 0;
    @(posedge clk);
    #1;
  endtask
  task automatic open_cs;
    @(posedge clk);
    #1;
    reg_cs = 1;
  endtask
  task automatic close_cs;
    reg_cs = 0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    open_cs();
    go(a, 1'b1, v);
    close_cs();
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    open_cs();
    go(a, 1'b0, 8'h00);
    v = reg_rdata;
    close_cs();
  endtask
  // All six axis bytes in one window
  task automatic burst(output logic [47:0] w);
    open_cs();
    for (int i = 0; i < 6; i++)
    begin
      go(ADDR_X_LOW + 6'(i), 1'b0, 8'h00);
      w[8*i +: 8] = reg_rdata;
    end
    close_cs();
  endtask
endmodule

// File: testbench.sv
// Purpose: Self-checking bench for the sample buffer
// Assumes: Host model performs every register cycle
// Notes: The x word of each sample is its sequence number
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    n_tests++; \
    if ((a) !== (b)) \
    begin \
      bad_count++; \
      $display("[FAIL] t=%0t got %h exp %h", $time, a, b); \
    end \
  end
module testbench;
  import accel_fifo_pkg::*;
  // --------------------------------------------------------------------
  // Stimulus and scenarios
  // --------------------------------------------------------------------
  logic clk = 0, rst = 1, sample_clk = 0, sample_valid = 0, sleep_mode = 0;
  logic activity_event = 0, inactivity_event = 0, reg_cs, reg_rd, reg_wr;
  logic first_interrupt_pin, second_interrupt_pin;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, int_enable = 8'h00, int_map = 8'h00, int_source_flags, d;
  logic [15:0] seq = 16'h0000, base;
  logic [47:0] x;
  int bad_count = 0, n_tests = 0;
  always #4 clk = ~clk;
  initial
  begin
    #3;
    forever #40 sample_clk = ~sample_clk;
  end
  accel_sample_fifo_control u_accel_sample_fifo_control (.clk(clk), .rst(rst),
    .sample_clk(sample_clk), .sample_valid(sample_valid), .sample_x(seq), .sample_y(~seq),
    .sample_z(seq ^ 16'h5a5a), .reg_cs(reg_cs), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sleep_mode(sleep_mode),
    .int_enable(int_enable), .int_map(int_map), .activity_event(activity_event),
    .inactivity_event(inactivity_event), .first_interrupt_pin(first_interrupt_pin),
    .second_interrupt_pin(second_interrupt_pin), .int_source_flags(int_source_flags));
  host_model u_host_model (.clk(clk), .reg_rdata(reg_rdata), .reg_cs(reg_cs),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata));
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Expected z, y, x word of sample number n
  function automatic logic [47:0] smp(input logic [15:0] n);
    return {n ^ 16'h5a5a, ~n, n};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic push(input int n);
    repeat (n)
    begin
      @(posedge sample_clk);
      #1;
      sample_valid = 1;
      @(posedge sample_clk);
      #1;
      sample_valid = 0;
      seq++;
      repeat (3) @(posedge sample_clk);
    end
    tick(12);
  endtask
  task automatic rs;
    u_host_model.rd(ADDR_BUFFER_STATUS, d);
  endtask
  task automatic start(input logic [7:0] c);
    u_host_model.wr(ADDR_BUFFER_CONTROL, 8'h00);
    u_host_model.wr(ADDR_BUFFER_CONTROL, c);
    // Pop after the mode write drops the stale entry and clears held flags
    u_host_model.burst(x);
    base = seq;
  endtask
  task automatic t_reset;
    u_host_model.rd(ADDR_BUFFER_CONTROL, d);
    `CHK(d, BUFFER_CONTROL_RESET)
    rs();
    `CHK(d, 8'h00)
    u_host_model.rd(6'h3f, d);
    `CHK(d, 8'h00)
    `CHK(int_source_flags[SRC_WATERMARK], 1'b1)
    u_host_model.wr(ADDR_BUFFER_CONTROL, 8'h9f);
    u_host_model.rd(ADDR_BUFFER_CONTROL, d);
    `CHK(d, 8'h9f)
    u_host_model.wr(ADDR_BUFFER_CONTROL, 8'h00);
  endtask
  task automatic t_route;
    int_enable = 8'h02;
    tick(4);
    `CHK({first_interrupt_pin, second_interrupt_pin}, 2'b10)
    int_map = 8'h02;
    tick(4);
    `CHK({first_interrupt_pin, second_interrupt_pin}, 2'b01)
    int_enable = 8'h00;
  endtask
  task automatic t_fill;
    start(8'h48);
    push(8);
    `CHK(int_source_flags[SRC_WATERMARK], 1'b0)
    push(1);
    `CHK(int_source_flags[SRC_WATERMARK], 1'b1)
    push(25);
    rs();
    `CHK(d, 8'h21)
    `CHK(int_source_flags[SRC_OVERRUN], 1'b1)
    u_host_model.burst(x);
    `CHK(x, smp(base))
    tick(3);
    `CHK(int_source_flags[SRC_OVERRUN], 1'b0)
    rs();
    `CHK(d, 8'h20)
    u_host_model.burst(x);
    `CHK(x, smp(base + 16'h0001))
    push(1);
    rs();
    `CHK(d, 8'h20)
  endtask
  task automatic t_stream;
    start(8'h9f);
    push(34);
    rs();
    `CHK(d, 8'h21)
    `CHK(int_source_flags[SRC_OVERRUN], 1'b1)
    u_host_model.burst(x);
    `CHK(x, smp(base))
    u_host_model.burst(x);
    `CHK(x, smp(base + 16'h0002))
  endtask
  task automatic t_bypass_sleep;
    start(8'h05);
    push(3);
    `CHK(int_source_flags[SRC_DATA_READY], 1'b1)
    rs();
    `CHK(d, 8'h01)
    u_host_model.burst(x);
    `CHK(x, smp(base + 16'h0002))
    sleep_mode = 1;
    tick(40);
    push(2);
    `CHK(int_source_flags[SRC_DATA_READY], 1'b0)
    rs();
    `CHK(d, 8'h00)
    sleep_mode = 0;
  endtask
  task automatic t_trigger;
    int i;
    int_enable = 8'h10;
    int_map = 8'h10;
    start(8'hc2);
    activity_event = 1;
    tick(10);
    rs();
    `CHK(d[STATUS_TRIG_BIT], 1'b0)
    activity_event = 0;
    u_host_model.wr(ADDR_BUFFER_CONTROL, 8'he2);
    push(6);
    rs();
    `CHK(d[STATUS_TRIG_BIT], 1'b0)
    activity_event = 1;
    for (i = 0; i < 50 && second_interrupt_pin !== 1'b1; i++)
      tick(1);
    if (i == 50)
    begin
      bad_count++;
      finish_test();
    end
    tick(3);
    rs();
    `CHK(d, 8'h83)
    u_host_model.burst(x);
    `CHK(x, smp(base))
    u_host_model.burst(x);
    `CHK(x, smp(base + 16'h0004))
    activity_event = 0;
    int_enable = 8'h00;
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    #1;
    rst = 0;
    tick(2);
    t_reset();
    t_route();
    t_fill();
    t_stream();
    t_bypass_sleep();
    t_trigger();
    finish_test();
  end
endmodule
